// ### logic/pces_cfg.svh
// Purpose: constants of the precharge exit status block
// Assumes: 20 MHz clock
// Notes:   exit and stage codes are 4-bit fields of the status outputs
`ifndef PCES_CFG_SVH
`define PCES_CFG_SVH

// clock and timing figures
`define PCES_CLK_HZ        20000000
`define PCES_ACK_MS        1000
`define PCES_TOUT_S        30

// exit status codes, held until the next start
`define PCES_EXIT_NONE     4'h0
`define PCES_EXIT_OK       4'h1
`define PCES_EXIT_MAIN     4'h2
`define PCES_EXIT_CHARGE   4'h3
`define PCES_EXIT_USER     4'h4
`define PCES_EXIT_TOUT     4'h5

// stage codes reported with a user abort
`define PCES_STG_VOLT      4'h0
`define PCES_STG_PRE_DAMP  4'h1
`define PCES_STG_DAMP_CL   4'h2
`define PCES_STG_CHG_OP    4'h3
`define PCES_STG_HOLD_CL   4'h4
`define PCES_STG_DAMP_OP   4'h5
`define PCES_STG_RESET     4'h6
`define PCES_STG_DIAG      4'h7
`define PCES_STG_POST_DIAG 4'h8
`define PCES_STG_SYNC      4'h9
`define PCES_STG_STARTUP   4'hF

`endif

// ### logic/pces_pkg.sv
// Purpose: types of the precharge exit status block
// Assumes: nothing beyond the cfg header
// Notes:   state is one packed struct
package pces_pkg;

    typedef enum logic [3:0] {
        ST_IDLE, ST_MAIN_OPEN, ST_CHG_CLOSE, ST_VOLT, ST_DAMP_CLOSE, ST_CHG_OPEN,
        ST_HOLD_CLOSE, ST_DAMP_OPEN, ST_DIAG_ENTRY, ST_WAIT_RESET, ST_DIAG,
        ST_POST_DIAG, ST_MAINT_LOG, ST_SYNC
    } pces_state_t;

    // pin inputs: contactor acknowledges, supervisory and drive condition pins, synchronised
    typedef struct packed {
        logic main_open;
        logic charge_closed;
        logic damp_closed;
        logic hold_closed;
        logic enable;
        logic start;
        logic volts_ok;
        logic cell_fault;
        logic diag_done;
        logic maint;
        logic in_sync;
    } pces_in_t;

    typedef struct packed {
        pces_in_t    s1;
        pces_in_t    s2;
        logic        start_prev;
        pces_state_t st;
        logic [29:0] step_cnt;
        logic [29:0] tout_cnt;
        logic [3:0]  exit_code;
        logic [3:0]  stage;
        logic        exit_pulse;
        logic        step_pulse;
        logic        maint_pulse;
        logic        done_pulse;
        logic        pre_fault;
        logic        main_fault;
        logic        alarm;
    } pces_regs_t;

endpackage : pces_pkg

// ### logic/pces_top.sv
// Purpose: exit status and fault reporting of a contactor precharge sequencer
// Assumes: all inputs are pins, synchronised here; one clock
// Notes:   exit code stays until the next start
`timescale 1ns/10ps
`include "pces_cfg.svh"

module pces_top #(
    parameter int ACK_CYC  = (`PCES_ACK_MS * (`PCES_CLK_HZ / 1000)),
    parameter int TOUT_CYC = (`PCES_TOUT_S * `PCES_CLK_HZ)
) (
    // clock and reset
    input  wire logic       I_CLOCK,
    input  wire logic       I_RSTN,
    // supervisory pins
    input  wire logic       I_START,
    input  wire logic       I_ENABLE,
    input  wire logic       I_MAINT,
    // contactor acknowledges
    input  wire logic       I_MAIN_OPEN,
    input  wire logic       I_CHARGE_CLOSED,
    input  wire logic       I_DAMP_CLOSED,
    input  wire logic       I_HOLD_CLOSED,
    // drive condition pins
    input  wire logic       I_VOLTS_OK,
    input  wire logic       I_CELL_FAULT,
    input  wire logic       I_DIAG_DONE,
    input  wire logic       I_IN_SYNC,
    // contactor commands
    output logic            O_CHARGE_CLOSE,
    output logic            O_DAMP_CLOSE,
    output logic            O_HOLD_CLOSE,
    // status
    output logic            O_BUSY,
    output logic [3:0]      O_EXIT_CODE,
    output logic            O_EXIT_VALID,
    output logic [3:0]      O_ABORT_STAGE,
    output logic            O_STEP_EVENT,
    output logic            O_MAINT_EVENT,
    output logic            O_DONE_EVENT,
    output logic            O_PRECHARGE_FAULT,
    output logic            O_MAIN_FAULT,
    output logic            O_CONTACTOR_ALARM
);

    localparam logic [29:0] ACK_LIM  = 30'(ACK_CYC);
    localparam logic [29:0] TOUT_LIM = 30'(TOUT_CYC);

    pces_pkg::pces_regs_t r_q;
    pces_pkg::pces_regs_t r_d;
    pces_pkg::pces_in_t   pins;

    // stage code of a state, for abort reporting
    function automatic logic [3:0] stage_of(input pces_pkg::pces_state_t s);
        case (s)
            pces_pkg::ST_VOLT:       stage_of = `PCES_STG_VOLT;
            pces_pkg::ST_DAMP_CLOSE: stage_of = `PCES_STG_PRE_DAMP;
            pces_pkg::ST_CHG_OPEN:   stage_of = `PCES_STG_DAMP_CL;
            pces_pkg::ST_HOLD_CLOSE: stage_of = `PCES_STG_CHG_OP;
            pces_pkg::ST_DAMP_OPEN:  stage_of = `PCES_STG_HOLD_CL;
            pces_pkg::ST_DIAG_ENTRY: stage_of = `PCES_STG_DAMP_OP;
            pces_pkg::ST_WAIT_RESET: stage_of = `PCES_STG_RESET;
            pces_pkg::ST_DIAG:       stage_of = `PCES_STG_DIAG;
            pces_pkg::ST_POST_DIAG:  stage_of = `PCES_STG_POST_DIAG;
            pces_pkg::ST_MAINT_LOG:  stage_of = `PCES_STG_POST_DIAG;
            pces_pkg::ST_SYNC:       stage_of = `PCES_STG_SYNC;
            default:                 stage_of = `PCES_STG_STARTUP;
        endcase
    endfunction : stage_of

    // pin bundle
    assign pins = '{main_open: I_MAIN_OPEN, charge_closed: I_CHARGE_CLOSED,
                    damp_closed: I_DAMP_CLOSED, hold_closed: I_HOLD_CLOSED,
                    enable: I_ENABLE, start: I_START, volts_ok: I_VOLTS_OK,
                    cell_fault: I_CELL_FAULT, diag_done: I_DIAG_DONE,
                    maint: I_MAINT, in_sync: I_IN_SYNC};

    ////////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        logic busy;
        logic start_rise;
        busy       = 1'b0;
        start_rise = 1'b0;
        r_d = r_q;
        r_d.s1 = pins;                                  // first sync stage
        r_d.s2 = r_q.s1;
        r_d.start_prev  = r_q.s2.start;
        r_d.exit_pulse  = 1'b0;
        r_d.step_pulse  = 1'b0;
        r_d.maint_pulse = 1'b0;
        r_d.done_pulse  = 1'b0;
        r_d.step_cnt    = r_q.step_cnt + 30'h0000_0001;
        r_d.tout_cnt    = r_q.tout_cnt + 30'h0000_0001;
        busy       = (r_q.st != pces_pkg::ST_IDLE);
        start_rise = r_q.s2.start && !r_q.start_prev;
        if (!busy) begin
            r_d.tout_cnt = '0;
            if (start_rise) begin
                // new run clears the previous record
                r_d.st         = pces_pkg::ST_MAIN_OPEN;
                r_d.exit_code  = `PCES_EXIT_NONE;
                r_d.stage      = `PCES_STG_STARTUP;
                r_d.pre_fault  = 1'b0;
                r_d.main_fault = 1'b0;
                r_d.alarm      = 1'b0;
                r_d.step_cnt   = '0;
                r_d.step_pulse = 1'b1;
            end
        end else if (!r_q.s2.enable) begin
            // user abort wins over any step
            r_d.st         = pces_pkg::ST_IDLE;
            r_d.exit_code  = `PCES_EXIT_USER;
            r_d.pre_fault  = 1'b1;
            r_d.stage      = stage_of(r_q.st);
            r_d.exit_pulse = 1'b1;
        end else if (r_q.tout_cnt >= TOUT_LIM - 30'h0000_0001 &&
                     r_q.st >= pces_pkg::ST_CHG_CLOSE &&
                     r_q.st <= pces_pkg::ST_DAMP_OPEN) begin
            r_d.st         = pces_pkg::ST_IDLE;
            r_d.exit_code  = `PCES_EXIT_TOUT;
            r_d.pre_fault  = 1'b1;
            r_d.exit_pulse = 1'b1;
        end else begin
            case (r_q.st)
                pces_pkg::ST_MAIN_OPEN: begin
                    if (r_q.s2.main_open) begin
                        r_d.st = pces_pkg::ST_CHG_CLOSE;
                    end else begin
                        r_d.st         = pces_pkg::ST_IDLE;
                        r_d.exit_code  = `PCES_EXIT_MAIN;
                        r_d.main_fault = 1'b1;
                        r_d.exit_pulse = 1'b1;
                    end
                end
                pces_pkg::ST_CHG_CLOSE: begin
                    if (r_q.s2.charge_closed) begin
                        r_d.st = pces_pkg::ST_VOLT;
                    end else if (r_q.step_cnt >= ACK_LIM - 30'h0000_0001) begin
                        r_d.st         = pces_pkg::ST_IDLE;
                        r_d.exit_code  = `PCES_EXIT_CHARGE;
                        r_d.pre_fault  = 1'b1;
                        r_d.alarm      = 1'b1;
                        r_d.exit_pulse = 1'b1;
                    end
                end
                pces_pkg::ST_VOLT:
                    if (r_q.s2.volts_ok) r_d.st = pces_pkg::ST_DAMP_CLOSE;
                pces_pkg::ST_DAMP_CLOSE:
                    if (r_q.s2.damp_closed) r_d.st = pces_pkg::ST_CHG_OPEN;
                pces_pkg::ST_CHG_OPEN:
                    if (!r_q.s2.charge_closed) r_d.st = pces_pkg::ST_HOLD_CLOSE;
                pces_pkg::ST_HOLD_CLOSE:
                    if (r_q.s2.hold_closed) r_d.st = pces_pkg::ST_DAMP_OPEN;
                pces_pkg::ST_DAMP_OPEN:
                    if (!r_q.s2.damp_closed) r_d.st = pces_pkg::ST_DIAG_ENTRY;
                pces_pkg::ST_DIAG_ENTRY:
                    r_d.st = pces_pkg::ST_DIAG;
                pces_pkg::ST_DIAG: begin
                    if (r_q.s2.cell_fault) r_d.st = pces_pkg::ST_WAIT_RESET;
                    else if (r_q.s2.diag_done) r_d.st = pces_pkg::ST_POST_DIAG;
                end
                pces_pkg::ST_WAIT_RESET:
                    if (!r_q.s2.cell_fault) r_d.st = pces_pkg::ST_DIAG;
                pces_pkg::ST_POST_DIAG: begin
                    if (r_q.s2.maint) begin
                        r_d.st          = pces_pkg::ST_MAINT_LOG;
                        r_d.maint_pulse = 1'b1;
                    end else begin
                        r_d.st = pces_pkg::ST_SYNC;
                    end
                end
                pces_pkg::ST_MAINT_LOG, pces_pkg::ST_SYNC: begin
                    if (r_q.st == pces_pkg::ST_MAINT_LOG || r_q.s2.in_sync) begin
                        r_d.st         = pces_pkg::ST_IDLE;
                        r_d.exit_code  = `PCES_EXIT_OK;
                        r_d.done_pulse = 1'b1;
                        r_d.exit_pulse = 1'b1;
                    end
                end
                default: r_d.st = pces_pkg::ST_IDLE;
            endcase
            if (r_d.st != r_q.st && r_d.st != pces_pkg::ST_IDLE) begin
                r_d.step_pulse = 1'b1;
                r_d.step_cnt   = '0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            r_q <= '0;
        end else begin
            r_q <= r_d;
        end
    end

    // outputs
    assign O_CHARGE_CLOSE    = (r_q.st == pces_pkg::ST_CHG_CLOSE) ||
                               (r_q.st == pces_pkg::ST_VOLT) ||
                               (r_q.st == pces_pkg::ST_DAMP_CLOSE);
    assign O_DAMP_CLOSE      = (r_q.st >= pces_pkg::ST_DAMP_CLOSE) &&
                               (r_q.st <= pces_pkg::ST_HOLD_CLOSE);
    assign O_HOLD_CLOSE      = (r_q.st >= pces_pkg::ST_HOLD_CLOSE);
    assign O_BUSY            = (r_q.st != pces_pkg::ST_IDLE);
    assign O_EXIT_CODE       = r_q.exit_code;
    assign O_EXIT_VALID      = r_q.exit_pulse;
    assign O_ABORT_STAGE     = r_q.stage;
    assign O_STEP_EVENT      = r_q.step_pulse;
    assign O_MAINT_EVENT     = r_q.maint_pulse;
    assign O_DONE_EVENT      = r_q.done_pulse;
    assign O_PRECHARGE_FAULT = r_q.pre_fault;
    assign O_MAIN_FAULT      = r_q.main_fault;
    assign O_CONTACTOR_ALARM = r_q.alarm;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    sequence seq_maint_then_done;
        O_MAINT_EVENT ##1 (O_DONE_EVENT && O_EXIT_VALID);
    endsequence

    AST_EXIT_AFTER_STEP: assert property (@(posedge I_CLOCK) disable iff (!I_RSTN)
        O_EXIT_VALID |-> !O_STEP_EVENT && !O_BUSY)
        else $error("exit recorded while sequence still busy");
    AST_OK_NO_FAULT: assert property (@(posedge I_CLOCK) disable iff (!I_RSTN)
        O_EXIT_VALID && O_EXIT_CODE == `PCES_EXIT_OK |->
        !O_PRECHARGE_FAULT && !O_MAIN_FAULT && !O_CONTACTOR_ALARM && O_DONE_EVENT)
        else $error("success exit carries a fault");
    AST_MAINT_ORDER: assert property (@(posedge I_CLOCK) disable iff (!I_RSTN)
        O_MAINT_EVENT && r_q.s2.enable |-> seq_maint_then_done)
        else $error("maintenance event not followed by completion");
    AST_MAIN_FAIL: assert property (@(posedge I_CLOCK) disable iff (!I_RSTN)
        r_q.st == pces_pkg::ST_MAIN_OPEN && !r_q.s2.main_open && r_q.s2.enable |=>
        O_EXIT_CODE == `PCES_EXIT_MAIN && O_MAIN_FAULT && !O_PRECHARGE_FAULT)
        else $error("main contactor failure not reported");
    AST_CHARGE_FAIL: assert property (@(posedge I_CLOCK) disable iff (!I_RSTN)
        O_EXIT_VALID && O_EXIT_CODE == `PCES_EXIT_CHARGE |->
        O_PRECHARGE_FAULT && O_CONTACTOR_ALARM && $past(r_q.step_cnt) == ACK_LIM - 1)
        else $error("charge contactor failure at wrong time or without alarm");
    AST_USER_ABORT: assert property (@(posedge I_CLOCK) disable iff (!I_RSTN)
        O_BUSY && !r_q.s2.enable |=> O_EXIT_VALID && O_EXIT_CODE == `PCES_EXIT_USER
        && O_PRECHARGE_FAULT)
        else $error("enable loss did not abort");
    AST_ABORT_STAGE: assert property (@(posedge I_CLOCK) disable iff (!I_RSTN)
        O_BUSY && !r_q.s2.enable && r_q.st == pces_pkg::ST_SYNC |=>
        O_ABORT_STAGE == `PCES_STG_SYNC)
        else $error("abort stage not recorded");
    AST_TIMEOUT: assert property (@(posedge I_CLOCK) disable iff (!I_RSTN)
        O_EXIT_VALID && O_EXIT_CODE == `PCES_EXIT_TOUT |->
        $past(r_q.tout_cnt) == TOUT_LIM - 1 && O_PRECHARGE_FAULT)
        else $error("timeout not at thirty seconds");
    AST_CHARGE_AFTER_MAIN: assert property (@(posedge I_CLOCK) disable iff (!I_RSTN)
        $rose(O_CHARGE_CLOSE) |-> $past(r_q.s2.main_open))
        else $error("charge contactor closed before main confirmed open");
    AST_CODE_HELD: assert property (@(posedge I_CLOCK) disable iff (!I_RSTN)
        !O_BUSY && !$past(O_BUSY) |-> $stable(O_EXIT_CODE))
        else $error("exit code changed while idle");

endmodule : pces_top

// ### tb/pces_partner.sv
// Purpose: contactor model answering the sequencer's commands
// Assumes: each of the charge, damp and hold acks follows its command after a settable delay
// Notes:   knobs make the main contactor stick closed or the charge one stick open
`timescale 1ns/10ps

module pces_partner (
    // clock and reset
    input  wire logic i_clock,
    input  wire logic i_rstn,
    // test knobs
    input  wire logic i_slow,
    input  wire logic i_main_stuck,
    input  wire logic i_charge_stuck,
    // commands from the sequencer
    input  wire logic i_charge_close,
    input  wire logic i_damp_close,
    input  wire logic i_hold_close,
    // acknowledges to the sequencer
    output logic      o_main_open,
    output logic      o_charge_closed,
    output logic      o_damp_closed,
    output logic      o_hold_closed
);
    logic [2:0]      cmd;
    logic [2:0]      ack_q;
    logic [2:0][3:0] cnt_q;
    logic [3:0]      lim;

    ////////////////////////////////////////////////////////////////////////////
    // a stuck charge contactor never follows its close command
    assign cmd = {i_hold_close, i_damp_close, i_charge_close & ~i_charge_stuck};
    assign lim = i_slow ? 4'hC : 4'h4; // slow stays inside the ack window

    // each contactor moves once its command has stood for lim + 1 cycles
    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            ack_q <= '0;
            cnt_q <= '0;
        end else begin
            for (int k = 0; k < 3; k++) begin
                if (cmd[k] == ack_q[k]) begin
                    cnt_q[k] <= 4'h0;
                end else if (cnt_q[k] == lim) begin
                    ack_q[k] <= cmd[k];
                    cnt_q[k] <= 4'h0;
                end else begin
                    cnt_q[k] <= cnt_q[k] + 4'h1;
                end
            end
        end
    end

    // acks as seen at the pins
    assign o_main_open     = ~i_main_stuck;
    assign o_charge_closed = ack_q[0];
    assign o_damp_closed   = ack_q[1];
    assign o_hold_closed   = ack_q[2];
endmodule : pces_partner

// ### tb/tb.sv
// Purpose: self-checking bench of the precharge exit status block
// Assumes: short ack and timeout counts, contactor model on the far side
// Notes:   inputs move and outputs are sampled 1 ns after the rising edge
`timescale 1ns/10ps
`include "pces_cfg.svh"

module tb;
    localparam int ACK  = 20;
    localparam int TOUT = 200;
    // stimulus and knobs
    logic I_CLOCK = 1'b0, I_RSTN = 1'b0, I_START = 1'b0, I_ENABLE = 1'b1, I_MAINT = 1'b0;
    logic I_VOLTS_OK = 1'b1, I_CELL_FAULT = 1'b0, I_DIAG_DONE = 1'b1, I_IN_SYNC = 1'b1;
    logic slow = 1'b0, main_stuck = 1'b0, charge_stuck = 1'b0;
    // observed pins
    logic I_MAIN_OPEN, I_CHARGE_CLOSED, I_DAMP_CLOSED, I_HOLD_CLOSED;
    logic O_CHARGE_CLOSE, O_DAMP_CLOSE, O_HOLD_CLOSE, O_BUSY, O_EXIT_VALID, O_STEP_EVENT;
    logic O_MAINT_EVENT, O_DONE_EVENT, O_PRECHARGE_FAULT, O_MAIN_FAULT, O_CONTACTOR_ALARM;
    logic [3:0] O_EXIT_CODE, O_ABORT_STAGE;
    int err_total = 0, n_compared = 0, wd = 0, cyc, steps, maint_at, done_at, chg_at, t;
    logic [3:0] stg_list [5] = '{`PCES_STG_STARTUP, `PCES_STG_VOLT, `PCES_STG_RESET,
                                 `PCES_STG_DIAG, `PCES_STG_SYNC};

    ////////////////////////////////////////////////////////////////////////////
    // clock, 50 ns period
    always #25 I_CLOCK = ~I_CLOCK;

    pces_partner partner (.i_clock(I_CLOCK), .i_rstn(I_RSTN), .i_slow(slow),
        .i_main_stuck(main_stuck), .i_charge_stuck(charge_stuck),
        .i_charge_close(O_CHARGE_CLOSE), .i_damp_close(O_DAMP_CLOSE),
        .i_hold_close(O_HOLD_CLOSE), .o_main_open(I_MAIN_OPEN),
        .o_charge_closed(I_CHARGE_CLOSED), .o_damp_closed(I_DAMP_CLOSED),
        .o_hold_closed(I_HOLD_CLOSED));

    pces_top #(.ACK_CYC(ACK), .TOUT_CYC(TOUT)) dut (.I_CLOCK, .I_RSTN, .I_START, .I_ENABLE,
        .I_MAINT, .I_MAIN_OPEN, .I_CHARGE_CLOSED, .I_DAMP_CLOSED, .I_HOLD_CLOSED, .I_VOLTS_OK,
        .I_CELL_FAULT, .I_DIAG_DONE, .I_IN_SYNC, .O_CHARGE_CLOSE, .O_DAMP_CLOSE, .O_HOLD_CLOSE,
        .O_BUSY, .O_EXIT_CODE, .O_EXIT_VALID, .O_ABORT_STAGE, .O_STEP_EVENT, .O_MAINT_EVENT,
        .O_DONE_EVENT, .O_PRECHARGE_FAULT, .O_MAIN_FAULT, .O_CONTACTOR_ALARM);

    ////////////////////////////////////////////////////////////////////////////
    // shared helpers
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic tick();
        @(posedge I_CLOCK);
        #1;
    endtask : tick

    task automatic summarize();
        $display("comparisons %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : summarize

    // hang guard
    always @(posedge I_CLOCK) begin
        wd++;
        if (wd == 8000) begin
            err_total++;
            summarize();
        end
    end

    // raise start and wait for the run to begin; the old status must be gone
    task automatic start_run();
        tick();
        I_START = 1'b1;
        for (t = 0; t < 10 && O_BUSY !== 1'b1; t++) tick();
        I_START = 1'b0;
        check(O_BUSY, 1'b1);
        check({O_PRECHARGE_FAULT, O_MAIN_FAULT, O_CONTACTOR_ALARM}, 8'h00);
        check(O_ABORT_STAGE, `PCES_STG_STARTUP);
    endtask : start_run

    // follow a run to its exit, noting events on the way
    task automatic wait_exit(input int lim);
        steps = 0;
        maint_at = -1;
        done_at = -1;
        chg_at = -1;
        for (cyc = 0; cyc < lim; cyc++) begin
            tick();
            if (O_STEP_EVENT === 1'b1) steps++;
            if (O_MAINT_EVENT === 1'b1) maint_at = cyc;
            if (O_DONE_EVENT === 1'b1) done_at = cyc;
            if (O_CHARGE_CLOSE === 1'b1 && chg_at < 0) chg_at = cyc;
            if (O_EXIT_VALID === 1'b1) break;
        end
        check(O_EXIT_VALID, 1'b1);
        check(O_BUSY, 1'b0);
    endtask : wait_exit

    // exit status, then the same status still standing later
    task automatic expect_end(input logic [3:0] code, input logic pf, mf, al);
        check(O_EXIT_CODE, code);
        check({O_PRECHARGE_FAULT, O_MAIN_FAULT, O_CONTACTOR_ALARM}, {pf, mf, al});
        repeat (20) tick();
        check(O_EXIT_CODE, code);
        check(O_EXIT_VALID, 1'b0);
        check({O_CHARGE_CLOSE, O_DAMP_CLOSE, O_HOLD_CLOSE}, 8'h00);
    endtask : expect_end

    ////////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_complete(input logic s, input logic m);
        slow = s;
        I_MAINT = m;
        start_run();
        wait_exit(400);
        expect_end(`PCES_EXIT_OK, 1'b0, 1'b0, 1'b0);
        check(done_at == cyc, 1'b1);
        check(steps >= 7, 1'b1);
        check(maint_at == (m ? cyc - 1 : -1), 1'b1);
        slow = 1'b0;
        I_MAINT = 1'b0;
        $display("completion test done, slow %0d maint %0d", s, m);
    endtask : t_complete

    task automatic t_main_fail();
        main_stuck = 1'b1;
        start_run();
        wait_exit(20);
        expect_end(`PCES_EXIT_MAIN, 1'b0, 1'b1, 1'b0);
        check(chg_at < 0, 1'b1);
        main_stuck = 1'b0;
        $display("main contactor test done");
    endtask : t_main_fail

    task automatic t_charge_fail();
        charge_stuck = 1'b1;
        start_run();
        wait_exit(ACK + 40);
        expect_end(`PCES_EXIT_CHARGE, 1'b1, 1'b0, 1'b1);
        check(cyc - chg_at >= ACK && cyc - chg_at <= ACK + 1, 1'b1);
        charge_stuck = 1'b0;
        $display("charge contactor test done");
    endtask : t_charge_fail

    task automatic t_timeout();
        I_VOLTS_OK = 1'b0;
        start_run();
        wait_exit(TOUT + 100);
        expect_end(`PCES_EXIT_TOUT, 1'b1, 1'b0, 1'b0);
        check(cyc >= TOUT - 10 && cyc <= TOUT + 5, 1'b1);
        I_VOLTS_OK = 1'b1;
        $display("timeout test done");
    endtask : t_timeout

    // park the run in one stage, then withdraw the enable
    task automatic t_user(input logic [3:0] stg);
        logic [7:0] cmd_exp;
        I_VOLTS_OK = (stg != `PCES_STG_VOLT);
        I_CELL_FAULT = (stg == `PCES_STG_RESET);
        I_DIAG_DONE = (stg != `PCES_STG_DIAG);
        I_IN_SYNC = (stg != `PCES_STG_SYNC);
        I_ENABLE = (stg != `PCES_STG_STARTUP);
        start_run();
        repeat ((stg == `PCES_STG_STARTUP) ? 0 : (stg == `PCES_STG_VOLT) ? 60 : 150) tick();
        // charge closed while volts build, only holding closed from diagnostics on
        cmd_exp = (stg == `PCES_STG_VOLT) ? 8'h04 : (stg == `PCES_STG_STARTUP) ? 8'h00 : 8'h01;
        check({O_CHARGE_CLOSE, O_DAMP_CLOSE, O_HOLD_CLOSE}, cmd_exp);
        I_ENABLE = 1'b0;
        wait_exit(20);
        expect_end(`PCES_EXIT_USER, 1'b1, 1'b0, 1'b0);
        check(O_ABORT_STAGE, stg);
        {I_ENABLE, I_VOLTS_OK, I_CELL_FAULT, I_DIAG_DONE, I_IN_SYNC} = 5'b11011;
        $display("user abort test done, stage %h", stg);
    endtask : t_user

    ////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        repeat (16) @(posedge I_CLOCK);
        #1 I_RSTN = 1'b1;
        tick();
        check({O_BUSY, O_EXIT_CODE}, 8'h00);
        t_complete(1'b0, 1'b0);
        t_complete(1'b1, 1'b0);
        t_complete(1'b0, 1'b1);
        t_main_fail();
        t_charge_fail();
        t_timeout();
        foreach (stg_list[k]) t_user(stg_list[k]);
        summarize();
    end
endmodule : tb
